// [wtu_pkg.sv]
// Package with constants, carrier structs and state types of the watchdog timer unit.
package wtu_pkg;

  // System clock and the low-power RC oscillator rate that the watchdog counts from.
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned OSC_HZ = 32_000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / OSC_HZ;
  localparam int unsigned TICK_W = $clog2(TICK_CYCLES);

  // Base time-out of the prescaler alone, in microseconds, and the divide ratios derived from it.
  localparam int unsigned BASE_TMO_SHORT_US = 1000;
  localparam int unsigned BASE_TMO_LONG_US = 4000;
  localparam int unsigned PRE_SHORT_DIV = BASE_TMO_SHORT_US * OSC_HZ / 1_000_000;
  localparam int unsigned PRE_LONG_DIV = BASE_TMO_LONG_US * OSC_HZ / 1_000_000;
  localparam int unsigned PRE_SHORT_LOG2 = $clog2(PRE_SHORT_DIV);
  localparam int unsigned PRE_LONG_LOG2 = $clog2(PRE_LONG_DIV);
  localparam int unsigned PRE_W = PRE_LONG_LOG2;
  localparam int unsigned POST_SEL_W = 4;
  localparam int unsigned POST_W = 15;
  localparam int unsigned ELAPSED_W = PRE_W + POST_W + 1;

  // Register byte offsets.
  localparam logic [3:0] REG_CONFIG_OFS = 4'h0;
  localparam logic [3:0] REG_RESET_CTRL_OFS = 4'h4;
  localparam logic [3:0] REG_STATUS_OFS = 4'h8;

  // Watchdog configuration word fields.
  localparam int unsigned CFG_POST_LSB = 0;
  localparam int unsigned CFG_PRESCALE_BIT = 4;
  localparam int unsigned CFG_WINDOW_DISABLE_BIT = 6;
  localparam int unsigned CFG_HARD_ENABLE_BIT = 7;
  localparam logic [7:0] CONFIG_RESET = 8'hdf;

  // Reset control register fields.
  localparam int unsigned RC_IDLE_BIT = 2;
  localparam int unsigned RC_SLEEP_BIT = 3;
  localparam int unsigned RC_TIMEOUT_BIT = 4;
  localparam int unsigned RC_SOFT_ENABLE_BIT = 5;
  localparam int unsigned RC_EARLY_KICK_BIT = 6;

  // Status register fields.
  localparam int unsigned ST_ELAPSED_LSB = 0;
  localparam int unsigned ST_RUNNING_BIT = 24;
  localparam int unsigned ST_OSC_BIT = 25;
  localparam int unsigned ST_PWR_LSB = 26;
  localparam int unsigned ST_LOCK_BIT = 28;

  typedef enum logic [1:0] {WTU_RUN, WTU_SLEEP, WTU_IDLE} wtu_pwr_type;

  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } wtu_avs_req_type;

  typedef struct packed {
    wtu_pwr_type pwr;
    logic [TICK_W-1:0] tick;
    logic [PRE_W-1:0] pre;
    logic [POST_W-1:0] post;
    logic [7:0] cfg;
    logic cfg_lock;
    logic soft_enable_bit;
    logic timeout_flag;
    logic sleep_flag;
    logic idle_flag;
    logic early_flag;
    logic waitreq;
    logic [31:0] rdata;
    logic rst_pulse;
    logic wake_pulse;
    logic osc_en;
  } wtu_state_type;

  localparam wtu_state_type STATE_RESET = '{
    pwr: WTU_RUN, tick: '0, pre: '0, post: '0, cfg: CONFIG_RESET, cfg_lock: 1'b0,
    soft_enable_bit: 1'b0, timeout_flag: 1'b0, sleep_flag: 1'b0, idle_flag: 1'b0,
    early_flag: 1'b0, waitreq: 1'b1, rdata: 32'h0000_0000, rst_pulse: 1'b0,
    wake_pulse: 1'b0, osc_en: 1'b0};

endpackage

// [wtu_top.sv]
// Watchdog timer unit with prescaler, postscaler, window mode and an Avalon-MM register slave.
//
// Function
// - Count from RC oscillator; enabling starts the oscillator.
// - Prescaler divides by 32 or 128.
// - Prescaler alone gives 1 ms or 4 ms.
// - Postscaler ratio 1:1 to 1:32768 from four bits.
// - Any device reset clears all counts.
// - Completed clock switch clears all counts.
// - Entering and leaving sleep or idle clears counts.
// - Kick instruction in normal running clears counts.
// - Keeps counting asleep; time-out wakes, no reset.
// - Hard enable fuse set forces watchdog always on.
// - Fuse clear: soft enable bit gates the watchdog.
// - Every device reset clears the soft enable bit.
// - Window mode: kick before last quarter resets device.
// - Time-out sets sticky flag; only software clears it.
`timescale 1ns/1ps
`default_nettype none

module wtu_top (
  // Clock, reset and clock enable.
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic CE_I,
  // Avalon-MM register slave.
  input wire wtu_pkg::wtu_avs_req_type AVS_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  // Core events.
  input wire logic DEV_RESET_I,
  input wire logic CLK_SWITCH_DONE_I,
  input wire logic KICK_I,
  input wire logic POWER_SAVE_I,
  input wire logic POWER_SAVE_SLEEP_I,
  input wire logic WAKE_EVENT_I,
  // Watchdog outputs.
  output logic WATCHDOG_RESET_O,
  output logic WAKE_O,
  output logic OSC_EN_O,
  output logic WATCHDOG_RUNNING_O
);
  import wtu_pkg::*;

  wtu_state_type s_reg;
  wtu_state_type s_next;

  logic enabled;
  logic tick_hit;
  logic [2:0] shamt;
  logic [PRE_W-1:0] pre_max;
  logic [POST_W-1:0] post_max;
  logic [ELAPSED_W-1:0] elapsed;
  logic [ELAPSED_W-1:0] period;
  logic [ELAPSED_W-1:0] threshold;
  logic win_open;
  logic timeout;
  logic kick_run;
  logic early;
  logic entering;
  logic waking;
  logic wd_reset;
  logic clear_counts;
  logic bus_req;
  logic bus_access;
  logic bus_done;
  logic [31:0] rd_value;

  always_comb begin
    s_next = s_reg;
    s_next.rst_pulse = 1'b0;
    s_next.wake_pulse = 1'b0;

    // The fuse overrides the soft bit, so clearing the soft bit cannot stop a fused watchdog.
    enabled = s_reg.cfg[CFG_HARD_ENABLE_BIT] | s_reg.soft_enable_bit;
    s_next.osc_en = enabled;

    // One tick per oscillator period, derived from the system clock.
    tick_hit = enabled && (s_reg.tick == TICK_W'(TICK_CYCLES - 1));
    if (!enabled || tick_hit) begin
      s_next.tick = '0;
    end else begin
      s_next.tick = s_reg.tick + TICK_W'(1);
    end

    // Prescaler ratio and postscaler limit.
    if (s_reg.cfg[CFG_PRESCALE_BIT]) begin
      shamt = 3'(PRE_LONG_LOG2);
      pre_max = PRE_W'(PRE_LONG_DIV - 1);
    end else begin
      shamt = 3'(PRE_SHORT_LOG2);
      pre_max = PRE_W'(PRE_SHORT_DIV - 1);
    end
    post_max = ~({POST_W{1'b1}} << s_reg.cfg[CFG_POST_LSB +: POST_SEL_W]);

    // Ticks elapsed in the current period and the start of its last quarter.
    elapsed = (ELAPSED_W'(s_reg.post) << shamt) | ELAPSED_W'(s_reg.pre);
    period = ELAPSED_W'(1) << (5'(shamt) + 5'(s_reg.cfg[CFG_POST_LSB +: POST_SEL_W]));
    threshold = period - (period >> 2);
    win_open = (elapsed >= threshold);

    timeout = tick_hit && (s_reg.pre == pre_max) && (s_reg.post == post_max);

    // Prescaler feeds the postscaler.
    if (tick_hit) begin
      if (s_reg.pre == pre_max) begin
        s_next.pre = '0;
        s_next.post = s_reg.post + POST_W'(1);
      end else begin
        s_next.pre = s_reg.pre + PRE_W'(1);
      end
    end

    kick_run = KICK_I && (s_reg.pwr == WTU_RUN);
    early = kick_run && enabled && !s_reg.cfg[CFG_WINDOW_DISABLE_BIT] && !win_open;
    entering = POWER_SAVE_I && (s_reg.pwr == WTU_RUN);
    waking = (s_reg.pwr != WTU_RUN) && (WAKE_EVENT_I || timeout);
    wd_reset = (timeout && (s_reg.pwr == WTU_RUN)) || early;

    // Avalon-MM slave: waitrequest drops one cycle after a request is seen.
    bus_req = AVS_I.read || AVS_I.write;
    bus_access = bus_req && s_reg.waitreq;
    bus_done = bus_req && !s_reg.waitreq;
    s_next.waitreq = !bus_access;

    rd_value = 32'h0000_0000;
    unique case (AVS_I.address)
      REG_CONFIG_OFS: begin
        rd_value[7:0] = s_reg.cfg;
      end
      REG_RESET_CTRL_OFS: begin
        rd_value[RC_IDLE_BIT] = s_reg.idle_flag;
        rd_value[RC_SLEEP_BIT] = s_reg.sleep_flag;
        rd_value[RC_TIMEOUT_BIT] = s_reg.timeout_flag;
        rd_value[RC_SOFT_ENABLE_BIT] = s_reg.soft_enable_bit;
        rd_value[RC_EARLY_KICK_BIT] = s_reg.early_flag;
      end
      REG_STATUS_OFS: begin
        rd_value[ST_ELAPSED_LSB +: ELAPSED_W] = elapsed;
        rd_value[ST_RUNNING_BIT] = enabled;
        rd_value[ST_OSC_BIT] = s_reg.osc_en;
        rd_value[ST_PWR_LSB +: 2] = s_reg.pwr;
        rd_value[ST_LOCK_BIT] = s_reg.cfg_lock;
      end
      default: begin
        rd_value = 32'h0000_0000;
      end
    endcase
    if (bus_access && AVS_I.read) begin
      s_next.rdata = rd_value;
    end

    // Writes take effect at the edge where the master sees waitrequest low.
    if (bus_done && AVS_I.write && AVS_I.byteenable[0]) begin
      unique case (AVS_I.address)
        REG_CONFIG_OFS: begin
          // Behaves like a fuse word: the first write after reset sticks.
          if (!s_reg.cfg_lock) begin
            s_next.cfg = AVS_I.writedata[7:0];
            s_next.cfg_lock = 1'b1;
          end
        end
        REG_RESET_CTRL_OFS: begin
          s_next.soft_enable_bit = AVS_I.writedata[RC_SOFT_ENABLE_BIT];
          s_next.timeout_flag = AVS_I.writedata[RC_TIMEOUT_BIT];
          s_next.sleep_flag = AVS_I.writedata[RC_SLEEP_BIT];
          s_next.idle_flag = AVS_I.writedata[RC_IDLE_BIT];
          s_next.early_flag = AVS_I.writedata[RC_EARLY_KICK_BIT];
        end
        default: begin
        end
      endcase
    end

    // Power-save sequencing.
    unique case (s_reg.pwr)
      WTU_RUN: begin
        if (entering) begin
          if (POWER_SAVE_SLEEP_I) begin
            s_next.pwr = WTU_SLEEP;
            s_next.sleep_flag = 1'b1;
          end else begin
            s_next.pwr = WTU_IDLE;
            s_next.idle_flag = 1'b1;
          end
        end
      end
      WTU_SLEEP, WTU_IDLE: begin
        if (waking) begin
          s_next.pwr = WTU_RUN;
          s_next.wake_pulse = timeout;
        end
      end
      default: begin
        s_next.pwr = WTU_RUN;
      end
    endcase

    // Hardware sets are applied after the software write so an event is never lost.
    if (timeout) begin
      s_next.timeout_flag = 1'b1;
    end
    if (early) begin
      s_next.early_flag = 1'b1;
    end

    // A watchdog reset is itself a device reset.
    if (wd_reset) begin
      s_next.rst_pulse = 1'b1;
      s_next.soft_enable_bit = 1'b0;
      s_next.pwr = WTU_RUN;
    end
    if (DEV_RESET_I) begin
      s_next.soft_enable_bit = 1'b0;
      s_next.pwr = WTU_RUN;
    end

    clear_counts = !enabled
                   || DEV_RESET_I
                   || CLK_SWITCH_DONE_I
                   || entering || waking
                   || kick_run
                   || timeout || early;
    if (clear_counts) begin
      s_next.pre = '0;
      s_next.post = '0;
    end
  end

  // The clock enable freezes everything, including the bus handshake.
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      s_reg <= STATE_RESET;
    end else if (CE_I) begin
      s_reg <= s_next;
    end
  end

  assign AVS_READDATA_O = s_reg.rdata;
  assign AVS_WAITREQUEST_O = s_reg.waitreq;
  assign WATCHDOG_RESET_O = s_reg.rst_pulse;
  assign WAKE_O = s_reg.wake_pulse;
  assign OSC_EN_O = s_reg.osc_en;
  assign WATCHDOG_RUNNING_O = s_reg.osc_en;

endmodule

`default_nettype wire

// [wtu_core_model.sv]
// Processor core model that issues kick, power-save, clock switch, wake and reset events.
`timescale 1ns/1ps
`default_nettype none
module wtu_core_model (
  // Clock and command from the bench.
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [2:0] op_i,
  // Event pulses and the sleep select level towards the watchdog.
  output logic kick_o,
  output logic psave_o,
  output logic sleep_o,
  output logic switch_o,
  output logic wake_o,
  output logic dev_reset_o
);
  // Every event but the sleep select, which follows op_i, lasts one cycle, since a longer device reset would act once per cycle.
  always_ff @(posedge clk_i) begin
    kick_o <= go_i && op_i == 3'h1;
    psave_o <= go_i && (op_i == 3'h2 || op_i == 3'h3);
    sleep_o <= op_i == 3'h2;
    switch_o <= go_i && op_i == 3'h4;
    wake_o <= go_i && op_i == 3'h5;
    dev_reset_o <= go_i && op_i == 3'h6;
  end
endmodule
`default_nettype wire

// [wtu_top_sva.sv]
// Assertion checker bound to the watchdog timer unit top module.
`timescale 1ns/1ps
`default_nettype none
module wtu_top_sva (
  // Clock, reset and clock enable.
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic CE_I,
  // Register bus.
  input wire wtu_pkg::wtu_avs_req_type AVS_I,
  input wire logic AVS_WAITREQUEST_O,
  // Core events and outputs.
  input wire logic DEV_RESET_I,
  input wire logic POWER_SAVE_I,
  input wire logic WAKE_EVENT_I,
  input wire logic WATCHDOG_RESET_O,
  input wire logic WAKE_O,
  input wire logic OSC_EN_O,
  input wire logic WATCHDOG_RUNNING_O
);
  import wtu_pkg::*;
  logic asleep_reg;
  // Mirrors the power state from the ports alone, so it needs no view of the body.
  always_ff @(posedge CLK_I) begin
    if (SRST_I || (CE_I && (DEV_RESET_I || WAKE_O || WAKE_EVENT_I)))
      asleep_reg <= 1'b0;
    else if (CE_I && POWER_SAVE_I)
      asleep_reg <= 1'b1;
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  a_wake_one_cycle: assert property (WAKE_O |=> !WAKE_O)
    else $error("wake pulse longer than one cycle");
  a_wake_from_sleep: assert property (WAKE_O |-> $past(asleep_reg))
    else $error("wake pulse while running");
  a_reset_from_run: assert property (WATCHDOG_RESET_O |-> !$past(asleep_reg))
    else $error("watchdog reset while asleep");
  a_reset_one_cycle: assert property (WATCHDOG_RESET_O |=> !WATCHDOG_RESET_O)
    else $error("reset pulse longer than one cycle");
  a_running_is_osc: assert property (WATCHDOG_RUNNING_O == OSC_EN_O)
    else $error("running and oscillator enable differ");
  a_stopped_no_wake: assert property (!OSC_EN_O ##1 !OSC_EN_O |-> !WAKE_O)
    else $error("wake pulse from a stopped watchdog");
  a_bus_answer: assert property ((AVS_I.read || AVS_I.write) && AVS_WAITREQUEST_O && CE_I
    |=> !AVS_WAITREQUEST_O) else $error("bus answer missing");
  a_wait_one_low: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
    else $error("waitrequest low for more than one cycle");
  a_srst_quiet: assert property (disable iff (1'b0) SRST_I |=> AVS_WAITREQUEST_O
    && !WATCHDOG_RESET_O && !WAKE_O && !OSC_EN_O) else $error("outputs active during reset");
endmodule
bind wtu_top wtu_top_sva i_wtu_top_sva (.CLK_I(CLK_I), .SRST_I(SRST_I), .CE_I(CE_I),
  .AVS_I(AVS_I), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .DEV_RESET_I(DEV_RESET_I),
  .POWER_SAVE_I(POWER_SAVE_I), .WAKE_EVENT_I(WAKE_EVENT_I),
  .WATCHDOG_RESET_O(WATCHDOG_RESET_O), .WAKE_O(WAKE_O), .OSC_EN_O(OSC_EN_O),
  .WATCHDOG_RUNNING_O(WATCHDOG_RUNNING_O));
`default_nettype wire

// [wtu_top_tb.sv]
// Self-checking testbench of the watchdog timer unit.
`timescale 1ns/1ps
`default_nettype none
module wtu_top_tb;
  import wtu_pkg::*;
  logic clk = 1'b0, srst = 1'b1, ce = 1'b1, go = 1'b0;
  logic [2:0] op = 3'h0;
  wtu_avs_req_type req = '0;
  logic [31:0] rdata, q;
  logic wreq, wd_rst, wake, osc, run, kick, pws, pws_sleep, csd, wev, drst;
  int error_cnt = 0, cmp_count = 0, rst_cnt = 0, wake_cnt = 0, n, i;
  initial forever #5 clk = ~clk;
  wtu_top i_wtu_top (.CLK_I(clk), .SRST_I(srst), .CE_I(ce), .AVS_I(req),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wreq), .DEV_RESET_I(drst),
    .CLK_SWITCH_DONE_I(csd), .KICK_I(kick), .POWER_SAVE_I(pws),
    .POWER_SAVE_SLEEP_I(pws_sleep), .WAKE_EVENT_I(wev), .WATCHDOG_RESET_O(wd_rst),
    .WAKE_O(wake), .OSC_EN_O(osc), .WATCHDOG_RUNNING_O(run));
  wtu_core_model i_wtu_core_model (.clk_i(clk), .go_i(go), .op_i(op), .kick_o(kick),
    .psave_o(pws), .sleep_o(pws_sleep), .switch_o(csd), .wake_o(wev), .dev_reset_o(drst));
  always @(posedge clk) begin
    if (wd_rst === 1'b1) rst_cnt++;
    if (wake === 1'b1) wake_cnt++;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Waits for waitrequest low with no assumed latency; the bound only stops a hang.
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    req <= '{read: !wr, write: wr, address: a, writedata: d, byteenable: 4'hf};
    do begin
      @(posedge clk);
      k++;
    end while (wreq !== 1'b0 && k < 100);
    q = rdata;
    req <= '0;
    @(posedge clk);
  endtask
  task ev(input logic [2:0] o);
    go <= 1'b1;
    op <= o;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #3_000_000;
    error_cnt++;
    stop_test;
  end
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
    chk(32'(osc), 32'h1);
    chk(32'(run), 32'h1);
    bus(1'b0, REG_CONFIG_OFS, 32'h0);
    chk(q, 32'(CONFIG_RESET));
    bus(1'b1, REG_RESET_CTRL_OFS, 32'h0);
    bus(1'b0, REG_STATUS_OFS, 32'h0);
    chk(32'(q[25:24]), 32'h3);
    $display("test fuse enable done");
    // The configuration is write-once, so window mode with 1:32 and 1:1 stays until the next system reset.
    bus(1'b1, REG_CONFIG_OFS, 32'h0);
    bus(1'b1, REG_CONFIG_OFS, 32'hff);
    bus(1'b0, REG_CONFIG_OFS, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, REG_STATUS_OFS, 32'h0);
    chk(32'(q[28:24]), 32'h10);
    bus(1'b1, REG_RESET_CTRL_OFS, 32'h20);
    repeat (3 * TICK_CYCLES) @(posedge clk);
    bus(1'b0, REG_STATUS_OFS, 32'h0);
    chk(32'(q[25:24]), 32'h3);
    chk(32'(q[22:0] >= 2), 32'h1);
    ev(3'h4);
    bus(1'b0, REG_STATUS_OFS, 32'h0);
    chk(32'(q[22:0] < 2), 32'h1);
    n = rst_cnt;
    ev(3'h1);
    repeat (4) @(posedge clk);
    chk(32'(rst_cnt - n), 32'h1);
    bus(1'b0, REG_RESET_CTRL_OFS, 32'h0);
    chk(32'(q[6:4]), 32'h4);
    $display("test window kick done");
    bus(1'b1, REG_RESET_CTRL_OFS, 32'h20);
    repeat (2 * TICK_CYCLES) @(posedge clk);
    ev(3'h2);
    bus(1'b0, REG_STATUS_OFS, 32'h0);
    chk(32'(q[27:26]), 32'h1);
    chk(32'(q[22:0] < 2), 32'h1);
    ev(3'h5);
    ev(3'h3);
    bus(1'b0, REG_STATUS_OFS, 32'h0);
    chk(32'(q[27:26]), 32'h2);
    ev(3'h5);
    n = rst_cnt;
    ev(3'h2);
    for (i = 0; i < 120_000 && wake_cnt == 0; i++) @(posedge clk);
    chk(32'(wake_cnt), 32'h1);
    chk(32'(rst_cnt - n), 32'h0);
    bus(1'b0, REG_RESET_CTRL_OFS, 32'h0);
    chk(32'(q[4:3]), 32'h3);
    bus(1'b0, REG_STATUS_OFS, 32'h0);
    chk(32'(q[27:26]), 32'h0);
    bus(1'b1, REG_RESET_CTRL_OFS, 32'h20);
    bus(1'b0, REG_RESET_CTRL_OFS, 32'h0);
    chk(32'(q[6:2]), 32'h8);
    $display("test sleep wake done");
    ev(3'h6);
    bus(1'b0, REG_RESET_CTRL_OFS, 32'h0);
    chk(32'(q[5]), 32'h0);
    bus(1'b0, REG_STATUS_OFS, 32'h0);
    chk(32'(q[25:24]), 32'h0);
    chk(32'(q[22:0]), 32'h0);
    bus(1'b0, 4'hc, 32'h0);
    chk(q, 32'h0);
    $display("test device reset done");
    // Second system reset in mid-run; window off, so a kick at any time only clears.
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
    chk(32'(run), 32'h1);
    bus(1'b1, REG_CONFIG_OFS, 32'h40);
    bus(1'b1, REG_RESET_CTRL_OFS, 32'h20);
    repeat (3 * TICK_CYCLES) @(posedge clk);
    bus(1'b0, REG_STATUS_OFS, 32'h0);
    chk(32'(q[22:0] >= 2), 32'h1);
    n = rst_cnt;
    ev(3'h1);
    bus(1'b0, REG_STATUS_OFS, 32'h0);
    chk(32'(q[22:0] < 2), 32'h1);
    chk(32'(rst_cnt - n), 32'h0);
    chk(32'(run), 32'h1);
    $display("test plain kick done");
    stop_test;
  end
endmodule
`default_nettype wire
